// file: core/fault_alarm_defs.vh
// Purpose: Register offsets, field positions and reset values for the fault alarm block.
// Assumes: Classic Wishbone slave with 32-bit data and word-aligned byte addresses.
// Notes: Offsets of the alarm mask and state registers are indices; byte address is 4x.
// Operation
// - Each fault source sets its own state flag independently of the others.
// - Alarm state register is readable over the bus at any time.
// - State register is read-only; a read clears all flags, which may then set again.
// - Open-drain alarm pin is driven active while any reported flag is set.
// - A set mask bit suppresses reporting of that source.
// - After reset thermal mask bit is clear; overvoltage and clamp mask bits are set.
// - Force-current mode: clamp alarm at voltage clamp levels only when clamp enabled.
// - A generated clamp alarm is still subject to the mask register.
// - Force-voltage mode: current clamps always active; clamp enable does not gate alarms. The code ignores the current clamps while clampLevelOutOfRange is set.
// - Force-voltage mode: alarm at current clamp levels, or the 140 percent static limit.
// - On a fault the block only sets flags, sets unmasked interrupt status bits and drives the alarm pin, nothing else.
// - Force-mode select bit 5 of measure control: 0 force-voltage, 1 force-current.
`ifndef FAULT_ALARM_DEFS_VH
`define FAULT_ALARM_DEFS_VH

`define IDX_MEAS_CTRL      7'h1c
`define IDX_ALARM_MASK     7'h1d
`define IDX_ALARM_STATE    7'h1e
`define IDX_IRQ_ENABLE     7'h40
`define IDX_IRQ_CLEAR      7'h41
`define IDX_IRQ_STATUS     7'h42

`define MEAS_CLAMP_EN_BIT  0
`define MEAS_FORCE_SEL_BIT 5
`define MEAS_CTRL_RESET    2'b00

// Alarm flag layout: overvoltage ch0/ch1, clamp ch0/ch1, thermal.
`define FLAG_WIDTH         5
`define FLAG_OV0           0
`define FLAG_OV1           1
`define FLAG_CLAMP0        2
`define FLAG_CLAMP1        3
`define FLAG_THERMAL       4
`define MASK_RESET         5'h0f
`define STATE_RESET        5'h00

// Static current limit as a percentage of full scale.
`define STATIC_LIMIT_PCT   8'd140

`endif

// file: core/fault_sync.v
`timescale 1ns/1ns
// Purpose: Three-stage synchroniser with agreement filter for asynchronous fault inputs.
// Assumes: One clock domain; srst synchronous active high.
// Notes: The first stage feeds only the second stage.
module fault_sync #(
    parameter WIDTH = 1
) (
    input  wire             clock,
    input  wire             srst,
    input  wire [WIDTH-1:0] asyncIn,
    output reg  [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] stage1_q;
    reg [WIDTH-1:0] stage2_q;
    reg [WIDTH-1:0] stage3_q;
    integer i;

    always @(posedge clock) begin
        if (srst) begin
            stage1_q <= {WIDTH{1'b0}};
            stage2_q <= {WIDTH{1'b0}};
            stage3_q <= {WIDTH{1'b0}};
            syncOut  <= {WIDTH{1'b0}};
        end else begin
            stage1_q <= asyncIn;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
            // A change counts only once the second and third stages agree.
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (stage2_q[i] == stage3_q[i]) begin
                    syncOut[i] <= stage3_q[i];
                end
            end
        end
    end
endmodule // fault_sync

// file: core/fault_alarm_flag_logic.v
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
// Purpose: Fault alarm aggregation with read-clear state, mask, interrupt and open-drain pin.
// Assumes: Analog comparators deliver level-reached indications asynchronously.
// Notes: Single clock; Wishbone classic slave answers every access one cycle after request.
//        Comparator levels are filtered before they reach the flags, so a fault shows
//        five clock edges after its input changes.
`include "fault_alarm_defs.vh"

module fault_alarm_flag_logic (
    input  wire        clock,
    input  wire        srst,
    // Wishbone classic slave.
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [31:0] wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output wire        wb_err_o,
    // Overvoltage detector comparisons, per channel.
    input  wire [1:0]  overvoltageLowDetector,
    input  wire [1:0]  overvoltageHighDetector,
    // Pin voltage reached clamp levels (force-current operation), per channel.
    input  wire [1:0]  pinVoltAtClampHigh,
    input  wire [1:0]  pinVoltAtClampLow,
    // Pin current reached clamp levels (force-voltage operation), per channel.
    input  wire [1:0]  pinCurrAtClampHigh,
    input  wire [1:0]  pinCurrAtClampLow,
    // Pin current beyond the static limit, per channel.
    input  wire [1:0]  pinCurrAtStaticLimit,
    // Clamp levels lie outside their functional range, per channel.
    input  wire [1:0]  clampLevelOutOfRange,
    input  wire        thermalFault,
    // Open-drain alarm pin, active low on the wire.
    input  wire        alarmPinIn,
    output wire        alarmPinOut,
    output wire        alarmPinOe,
    output wire        alarmActive,
    output wire        irq
);
    // Register map, word index and byte address:
    //   0x1c (0x070, 0x270)  measure control; bit 0 clamp enable, bit 5 force mode.
    //                        Bit 5 low selects force-voltage, high force-current.
    //                        Byte address bit 9 selects channel 1.
    //   0x1d (0x074)         alarm mask; a set bit suppresses that source.
    //   0x1e (0x078)         alarm state; read-only, cleared by every read.
    //   0x40 (0x100)         interrupt enable.
    //   0x41 (0x104)         interrupt clear; write ones to clear status bits.
    //   0x42 (0x108)         interrupt status; sticky, set by unmasked faults.
    // Flag layout in mask, state and interrupt registers:
    //   bit 0 overvoltage channel 0, bit 1 overvoltage channel 1,
    //   bit 2 clamp channel 0, bit 3 clamp channel 1, bit 4 thermal.
    // Other addresses below 0x400 with bit 9 set alias the register of the same index; all the rest ack and read zero, writes dropped.

    // Synchronised comparator levels. They are asynchronous to the clock, so each one
    // passes three flip-flops and counts only once the last two stages agree.
    wire [1:0] ovLowS;
    wire [1:0] ovHighS;
    wire [1:0] vHighS;
    wire [1:0] vLowS;
    wire [1:0] iHighS;
    wire [1:0] iLowS;
    wire [1:0] iStatS;
    wire [1:0] oorS;
    wire       thermS;

    // Overvoltage detectors of both channels.
    fault_sync #(.WIDTH(4)) u_sync_ov (
        .clock   (clock),
        .srst    (srst),
        .asyncIn ({overvoltageHighDetector, overvoltageLowDetector}),
        .syncOut ({ovHighS, ovLowS})
    );

    // Clamp level comparisons of both channels, voltage and current.
    fault_sync #(.WIDTH(12)) u_sync_clamp (
        .clock   (clock),
        .srst    (srst),
        .asyncIn ({clampLevelOutOfRange, pinCurrAtStaticLimit, pinCurrAtClampLow,
                   pinCurrAtClampHigh, pinVoltAtClampLow, pinVoltAtClampHigh}),
        .syncOut ({oorS, iStatS, iLowS, iHighS, vLowS, vHighS})
    );

    // Thermal sensor.
    fault_sync #(.WIDTH(1)) u_sync_therm (
        .clock   (clock),
        .srst    (srst),
        .asyncIn (thermalFault),
        .syncOut (thermS)
    );

    // Word index of a byte address. Bit 9 picks the channel of the measure control
    // register, so it is left out of the index; anything above it is unmapped.
    function [6:0] wordIndex;
        input [31:0] adr;
        begin
            wordIndex = (adr[31:10] == 22'h0) ? adr[8:2] : 7'h7f;
        end
    endfunction

    // Clamp alarm of one channel; one function keeps both channels alike.
    function clampQualify;
        input forceCurrent;
        input clampOn;
        input voltHigh;
        input voltLow;
        input currHigh;
        input currLow;
        input currStatic;
        input levelsOutOfRange;
        begin
            if (forceCurrent) begin
                // Voltage clamps report only while their enable is set.
                clampQualify = clampOn & (voltHigh | voltLow);
            end else if (levelsOutOfRange) begin
                // Unusable programmed levels leave only the static current limit.
                clampQualify = currStatic;
            end else begin
                // Current clamps are always active; the enable bit is not consulted.
                clampQualify = currHigh | currLow | currStatic;
            end
        end
    endfunction

    // An overvoltage flag merges the low and high detector of one channel.
    function overvoltQualify;
        input lowHit;
        input highHit;
        begin
            overvoltQualify = lowHit | highHit;
        end
    endfunction

    // Next value of a sticky flag set: a set in the clearing cycle wins.
    function [`FLAG_WIDTH-1:0] stickyNext;
        input [`FLAG_WIDTH-1:0] held;
        input [`FLAG_WIDTH-1:0] clear;
        input [`FLAG_WIDTH-1:0] set;
        begin
            stickyNext = (held & ~clear) | set;
        end
    endfunction

    // Places a flag field in the low bits of a bus word.
    function [31:0] flagWord;
        input [`FLAG_WIDTH-1:0] flags;
        begin
            flagWord = {{(32-`FLAG_WIDTH){1'b0}}, flags};
        end
    endfunction

    // True for every word index that holds a register.
    function addrMapped;
        input [6:0] index;
        begin
            case (index)
                `IDX_MEAS_CTRL,
                `IDX_ALARM_MASK,
                `IDX_ALARM_STATE,
                `IDX_IRQ_ENABLE,
                `IDX_IRQ_CLEAR,
                `IDX_IRQ_STATUS: addrMapped = 1'b1;
                default:         addrMapped = 1'b0;
            endcase
        end
    endfunction

    // Per-channel measure control: clamp enable and force-mode select.
    reg  [1:0]             clampEnable_q;
    reg  [1:0]             forceModeSelect_q;
    reg  [`FLAG_WIDTH-1:0] alarmMask_q;
    reg  [`FLAG_WIDTH-1:0] alarmState_q;
    reg  [`FLAG_WIDTH-1:0] alarmState_d;
    reg  [`FLAG_WIDTH-1:0] irqStatus_q;
    reg  [`FLAG_WIDTH-1:0] irqStatus_d;
    reg  [`FLAG_WIDTH-1:0] irqClearBits;
    reg  [`FLAG_WIDTH-1:0] irqEnable_q;
    reg  [`FLAG_WIDTH-1:0] faultNow;
    reg  [1:0]             clampFault;
    reg  [31:0]            readData;

    // A request is taken only while ack is low, so a held strobe is not taken twice.
    wire       request     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire [6:0] idx         = wordIndex(wb_adr_i);
    // Bit 9 of the byte address picks the measure control channel.
    wire       chanSel     = wb_adr_i[9];
    wire       mapped      = addrMapped(idx);
    wire       writeOp     = request & wb_we_i & wb_sel_i[0];
    wire       readOp      = request & ~wb_we_i;
    wire       readClear   = readOp & (idx == `IDX_ALARM_STATE);
    wire       writeMask   = writeOp & (idx == `IDX_ALARM_MASK);
    wire       writeMeas   = writeOp & (idx == `IDX_MEAS_CTRL);
    wire       writeIrqEn  = writeOp & (idx == `IDX_IRQ_ENABLE);
    wire       writeIrqClr = writeOp & (idx == `IDX_IRQ_CLEAR);

    // Present fault of every source, each on its own flag.
    always @* begin
        // Channel 0 clamp alarm.
        clampFault[0] = clampQualify(forceModeSelect_q[0],
                                     clampEnable_q[0],
                                     vHighS[0],
                                     vLowS[0],
                                     iHighS[0],
                                     iLowS[0],
                                     iStatS[0],
                                     oorS[0]);
        // Channel 1 clamp alarm.
        clampFault[1] = clampQualify(forceModeSelect_q[1],
                                     clampEnable_q[1],
                                     vHighS[1],
                                     vLowS[1],
                                     iHighS[1],
                                     iLowS[1],
                                     iStatS[1],
                                     oorS[1]);
        faultNow                = {`FLAG_WIDTH{1'b0}};
        faultNow[`FLAG_OV0]     = overvoltQualify(ovLowS[0], ovHighS[0]);
        faultNow[`FLAG_OV1]     = overvoltQualify(ovLowS[1], ovHighS[1]);
        faultNow[`FLAG_CLAMP0]  = clampFault[0];
        faultNow[`FLAG_CLAMP1]  = clampFault[1];
        faultNow[`FLAG_THERMAL] = thermS;
    end

    // Sticky flags. A fault in the clearing cycle survives the read-clear, so no
    // event is lost between one read and the next.
    always @* begin
        alarmState_d = stickyNext(alarmState_q, {`FLAG_WIDTH{readClear}}, faultNow);
    end

    // Interrupt status sets only for unmasked sources; a set beats a clear.
    always @* begin
        irqClearBits = writeIrqClr ? wb_dat_i[`FLAG_WIDTH-1:0] : {`FLAG_WIDTH{1'b0}};
        irqStatus_d  = stickyNext(irqStatus_q, irqClearBits, faultNow & ~alarmMask_q);
    end

    // Flags only record faults; no other state reacts to them.
    always @(posedge clock) begin
        if (srst) begin
            alarmState_q <= `STATE_RESET;
        end else begin
            alarmState_q <= alarmState_d;
        end
    end

    // Interrupt status register.
    always @(posedge clock) begin
        if (srst) begin
            irqStatus_q <= {`FLAG_WIDTH{1'b0}};
        end else begin
            irqStatus_q <= irqStatus_d;
        end
    end

    // Thermal reporting is on out of reset; the other sources start suppressed.
    always @(posedge clock) begin
        if (srst) begin
            alarmMask_q <= `MASK_RESET;
        end else if (writeMask) begin
            alarmMask_q <= wb_dat_i[`FLAG_WIDTH-1:0];
        end
    end

    // Measure control holds one copy per channel; address bit 9 selects it.
    always @(posedge clock) begin
        if (srst) begin
            clampEnable_q     <= 2'b00;
            forceModeSelect_q <= `MEAS_CTRL_RESET;
        end else if (writeMeas) begin
            clampEnable_q[chanSel]     <= wb_dat_i[`MEAS_CLAMP_EN_BIT];
            forceModeSelect_q[chanSel] <= wb_dat_i[`MEAS_FORCE_SEL_BIT];
        end
    end

    // Interrupt enable register.
    always @(posedge clock) begin
        if (srst) begin
            irqEnable_q <= {`FLAG_WIDTH{1'b0}};
        end else if (writeIrqEn) begin
            irqEnable_q <= wb_dat_i[`FLAG_WIDTH-1:0];
        end
    end

    // Read mux; the state register is reachable at any time.
    always @* begin
        readData = 32'h00000000;
        case (idx)
            `IDX_ALARM_STATE: begin
                readData = flagWord(alarmState_q);
            end
            `IDX_ALARM_MASK: begin
                readData = flagWord(alarmMask_q);
            end
            `IDX_MEAS_CTRL: begin
                readData[`MEAS_CLAMP_EN_BIT]  = clampEnable_q[chanSel];
                readData[`MEAS_FORCE_SEL_BIT] = forceModeSelect_q[chanSel];
            end
            `IDX_IRQ_ENABLE: begin
                readData = flagWord(irqEnable_q);
            end
            `IDX_IRQ_STATUS: begin
                readData = flagWord(irqStatus_q);
            end
            `IDX_IRQ_CLEAR: begin
                readData = 32'h00000000;
            end
            default: begin
                readData = 32'h00000000;
            end
        endcase
    end

    // Unmapped addresses still ack and read zero, so the master never hangs.
    always @(posedge clock) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= request;
        end
    end

    // Read data stands only with ack; zero otherwise keeps the idle bus quiet.
    always @(posedge clock) begin
        if (srst) begin
            wb_dat_o <= 32'h00000000;
        end else if (readOp && mapped) begin
            wb_dat_o <= readData;
        end else begin
            wb_dat_o <= 32'h00000000;
        end
    end

    // Every access completes normally; there is no error response.
    assign wb_err_o = 1'b0;

    // Masked OR of flags drives the open-drain pin low.
    assign alarmActive = |(alarmState_q & ~alarmMask_q);
    assign alarmPinOut = 1'b0;
    assign alarmPinOe  = alarmActive;
    assign irq         = |(irqStatus_q & irqEnable_q);
endmodule // fault_alarm_flag_logic

// file: tb/fault_alarm_asserts.sv
// Purpose: Port checker for the fault alarm block.
// Assumes: One clock; srst synchronous, active high.
// Notes: Flag timing is judged on the thermal input only.
`timescale 1ns/1ns
module fault_alarm_asserts (
    input wire        clock,
    input wire        srst,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [31:0] wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        wb_err_o,
    input wire        thermalFault,
    input wire        alarmPinOut,
    input wire        alarmPinOe,
    input wire        alarmActive,
    input wire        irq
);
    logic [2:0] heldCnt_q;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // Saturates so that a long fault never wraps back to a small count.
    always @(posedge clock)
        if (srst || !thermalFault) heldCnt_q <= 3'h0;
        else if (heldCnt_q != 3'h7) heldCnt_q <= heldCnt_q + 3'h1;
    a_ack_one_cycle: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o) else $error("ack pulse");
    a_ack_has_req: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
        else $error("ack without request");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_pin_tracks: assert property (alarmPinOe == alarmActive)
        else $error("alarm pin differs from alarm");
    a_pin_sinks: assert property (alarmPinOe |-> !alarmPinOut)
        else $error("alarm pin driven high");
    a_no_error: assert property (!wb_err_o)
        else $error("bus error raised");
    a_reset_quiet: assert property ($past(srst) |-> !alarmActive && !irq && !wb_ack_o)
        else $error("activity after reset");
    a_flag_reported: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 32'h78
        && heldCnt_q == 3'h7 |-> wb_dat_o[4]) else $error("thermal flag missing");
    c_flag_read: cover property (wb_ack_o && wb_dat_o != 32'h0);
    c_pin_low: cover property ($rose(alarmPinOe));
    c_irq_up: cover property ($rose(irq));
endmodule // fault_alarm_asserts

bind fault_alarm_flag_logic fault_alarm_asserts chk_u (.clock, .srst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .thermalFault, .alarmPinOut,
    .alarmPinOe, .alarmActive, .irq);

// file: tb/fault_source_model.sv
// Purpose: Analog fault sources and the pulled-up open-drain alarm wire.
// Assumes: Fault levels are asynchronous to the block clock.
// Notes: One register stage stands in for the comparator response.
`timescale 1ns/1ns
module fault_source_model (
    input  wire         clock,
    input  wire  [16:0] faultReq,
    input  wire         alarmPinOut,
    input  wire         alarmPinOe,
    output logic [16:0] faultLines,
    output wire         alarmWire
);
    initial faultLines = 17'h0;
    always @(posedge clock) faultLines <= faultReq;
    // A board pull-up holds the wire high whenever nobody sinks it.
    assign alarmWire = alarmPinOe ? alarmPinOut : 1'b1;
endmodule // fault_source_model

// file: tb/fault_alarm_flag_logic_test.sv
// Purpose: Self-checking bench for the fault alarm block.
// Assumes: Each Wishbone access is answered after one cycle.
// Notes: Faults cross a four-edge synchroniser, so waits allow eight cycles.
`timescale 1ns/1ns
module fault_alarm_flag_logic_test;
    logic        clock, srst, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [31:0] wb_adr_i, wb_dat_i, d;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o, alarmPinOut, alarmPinOe, alarmActive, irq, alarmWire;
    wire  [16:0] faultLines;
    logic [16:0] faultReq;
    logic [43:0] rows [12];
    int          miscompares, samplesChecked;
    always #5 clock = ~clock;
    fault_source_model model_u (.clock, .faultReq, .alarmPinOut, .alarmPinOe, .faultLines,
        .alarmWire);
    fault_alarm_flag_logic dut_u (.clock, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o(),
        .overvoltageLowDetector(faultLines[1:0]), .overvoltageHighDetector(faultLines[3:2]),
        .pinVoltAtClampHigh(faultLines[5:4]), .pinVoltAtClampLow(faultLines[7:6]),
        .pinCurrAtClampHigh(faultLines[9:8]), .pinCurrAtClampLow(faultLines[11:10]),
        .pinCurrAtStaticLimit(faultLines[13:12]), .clampLevelOutOfRange(faultLines[15:14]),
        .thermalFault(faultLines[16]), .alarmPinIn(alarmWire), .alarmPinOut, .alarmPinOe,
        .alarmActive, .irq);
    task automatic close_out;
        if (miscompares == 0 && samplesChecked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samplesChecked++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            miscompares++;
        end
    endtask
    task automatic bus(input logic we, input logic [31:0] adr, input logic [31:0] dat);
        int n;
        @(posedge clock);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, dat};
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        d = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        if (wb_ack_o !== 1'b1) begin
            miscompares++;
            close_out;
        end
    endtask
    task automatic rd(input logic [31:0] adr, input logic [31:0] exp);
        bus(1'b0, adr, 32'h0);
        chk($sformatf("read %h", adr), exp, d);
    endtask
    initial begin
        clock = 1'b0;
        srst = 1'b1;
        faultReq = 17'h0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        // Columns: mask, measure control, fault lines, expected state.
        rows = '{44'h0f_00_00001_01, 44'h00_00_00008_02, 44'h00_20_00010_00,
                 44'h00_21_00080_08, 44'h08_21_00080_08, 44'h00_00_00100_04,
                 44'h00_01_00800_08, 44'h00_00_04100_00, 44'h00_00_05000_04,
                 44'h00_21_00100_00, 44'h00_00_00010_00, 44'h0f_00_10000_10};
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        rd(32'h74, 32'h0f);
        rd(32'h200, 32'h0);
        bus(1'b1, 32'h78, 32'h1f);
        rd(32'h78, 32'h0);
        foreach (rows[i]) begin
            bus(1'b1, 32'h74, {24'h0, rows[i][43:36]});
            bus(1'b1, 32'h70, {24'h0, rows[i][35:28]});
            bus(1'b1, 32'h270, {24'h0, rows[i][35:28]});
            faultReq <= rows[i][24:8];
            repeat (8) @(posedge clock);
            chk("alarm", {31'h0, |(rows[i][7:0] & ~rows[i][43:36])}, {31'h0, alarmActive});
            faultReq <= 17'h0;
            repeat (8) @(posedge clock);
            rd(32'h78, {24'h0, rows[i][7:0]});
        end
        chk("irq masked", 32'h0, {31'h0, irq});
        bus(1'b1, 32'h100, 32'h1f);
        faultReq <= 17'h10000;
        repeat (8) @(posedge clock);
        chk("irq", 32'h1, {31'h0, irq});
        chk("alarm wire", 32'h0, {31'h0, alarmWire});
        rd(32'h78, 32'h10);
        rd(32'h78, 32'h10);
        faultReq <= 17'h0;
        repeat (8) @(posedge clock);
        rd(32'h78, 32'h10);
        rd(32'h78, 32'h0);
        chk("alarm wire", 32'h1, {31'h0, alarmWire});
        rd(32'h108, 32'h1e);
        bus(1'b1, 32'h104, 32'h1f);
        chk("irq cleared", 32'h0, {31'h0, irq});
        close_out;
    end
endmodule // fault_alarm_flag_logic_test
